// File: src/odt_device.sv
// DRAM-side termination control across power-down entry and exit
module odt_device #(
  parameter int unsigned CWL   = 5,
  parameter int unsigned AL    = 0,
  parameter int unsigned XPDLL = 10,
  parameter int unsigned RFC   = 11
) (
  input  wire logic              clock,
  input  wire logic              reset,
  odt_link_if.device             link,
  output logic                   rtt_on,
  output odt_pkg::odt_mode_t     mode,
  output logic                   window
);
  import odt_pkg::*;

  localparam logic [LAT_W-1:0] WL = LAT_W'(CWL + AL);
  localparam logic [LAT_W-1:0] ODTL_ON  = WL - ODTL_SUB;
  localparam logic [LAT_W-1:0] ODTL_OFF = WL - ODTL_SUB;
  localparam logic [LAT_W-1:0] ANPD     = WL - ANPD_SUB;
  localparam logic [CNT_W-1:0] XPDLL_C  = CNT_W'(XPDLL);
  localparam logic [CNT_W-1:0] RFC_C    = CNT_W'(RFC);
  localparam logic [CNT_W-1:0] ASYNC_C  = CNT_W'(ASYNC_CYC);

  logic [PIN_SYNC-1:0]   odt_sync;
  logic [PIN_SYNC-1:0]   cke_sync;
  logic [PIN_SYNC-1:0]   ref_sync;
  logic                  odt_s;
  logic                  cke_s;
  logic                  cke_prev;
  logic [MR0_W-1:0]      mr0;
  logic [PIPE_DEPTH-1:0] odt_pipe;
  logic [CNT_W-1:0]      pde_cnt;
  logic [CNT_W-1:0]      pdx_cnt;
  logic [CNT_W-1:0]      rfc_cnt;
  logic [CNT_W-1:0]      async_cnt;
  logic                  async_tgt;
  logic                  powered_down;

  // Changes count once the second and third stage agree
  wire odt_agree = odt_sync[1] == odt_sync[2];
  wire cke_agree = cke_sync[1] == cke_sync[2];
  wire next_odt_s = odt_agree ? odt_sync[2] : odt_s;
  wire next_cke_s = cke_agree ? cke_sync[2] : cke_s;
  wire ref_pulse  = ref_sync[1] & ref_sync[2];
  wire dll_off    = ~mr0[DLL_OFF_BIT];
  wire cke_fall   = cke_prev & ~cke_s;
  wire cke_rise   = ~cke_prev & cke_s;

  // The tANPD lead before a CKE edge is only visible after the fact, so the
  // synchronous pipe lags by ANPD and the lead is covered by that delay.
  wire sync_on  = odt_pipe[ODTL_ON];
  wire sync_off = odt_pipe[ODTL_OFF];
  wire pde_busy = pde_cnt != CNT_ZERO;
  wire pdx_busy = pdx_cnt != CNT_ZERO;
  // Overlapping windows merge into one uncertain span
  wire in_win   = dll_off & (pde_busy | pdx_busy);
  wire async_md = dll_off & powered_down & ~in_win;
  wire [CNT_W-1:0] rfc_left = rfc_cnt;
  wire [CNT_W-1:0] pde_len  =
    (rfc_left > CNT_W'(ANPD)) ? rfc_left : CNT_W'(ANPD);
  wire [CNT_W-1:0] pdx_len  = CNT_W'(ANPD) + XPDLL_C;
  wire [CNT_W-1:0] pde_dec    = pde_cnt - CNT_ONE;
  wire [CNT_W-1:0] pdx_dec    = pdx_cnt - CNT_ONE;
  wire [CNT_W-1:0] rfc_dec    = rfc_cnt - CNT_ONE;
  wire [CNT_W-1:0] async_dec  = async_cnt - CNT_ONE;
  wire             rfc_busy   = rfc_cnt != CNT_ZERO;
  wire             async_busy = async_cnt != CNT_ZERO;

  wire [CNT_W-1:0] next_pde =
    (dll_off & cke_fall) ? pde_len :
    pde_busy ? pde_dec : CNT_ZERO;
  wire [CNT_W-1:0] next_pdx =
    (dll_off & cke_rise) ? pdx_len :
    pdx_busy ? pdx_dec : CNT_ZERO;
  // A refresh seen on two samples merely restarts the count
  wire [CNT_W-1:0] next_rfc =
    ref_pulse ? RFC_C :
    rfc_busy ? rfc_dec : CNT_ZERO;

  // Async path bypasses AL and waits the analog delay only
  wire async_start = odt_s != async_tgt;
  wire [CNT_W-1:0] next_async =
    async_start ? ASYNC_C :
    async_busy ? async_dec : CNT_ZERO;

  // Inside a window either response is legal; the earlier turn-on is taken
  wire async_done = async_cnt == CNT_ONE;
  wire async_val  = async_done ? async_tgt : rtt_on;
  wire async_rise = async_done & async_tgt;
  // Turn-off in a window follows the sync tap, the latest legal point
  wire win_rtt    = ((async_val | sync_on) & sync_off) | async_rise;
  wire next_rtt   =
    async_md ? async_val :
    in_win   ? win_rtt :
    sync_on;
  wire odt_mode_t next_mode =
    async_md ? ODT_MODE_ASYNC : in_win ? ODT_MODE_MIXED : ODT_MODE_SYNC;

  // Three-stage synchronisers on the controller pins
  always_ff @(posedge clock) begin
    if (reset) begin
      odt_sync <= '0;
      cke_sync <= '0;
      ref_sync <= '0;
    end else begin
      odt_sync <= {odt_sync[PIN_SYNC-2:0], link.odt};
      cke_sync <= {cke_sync[PIN_SYNC-2:0], link.cke};
      ref_sync <= {ref_sync[PIN_SYNC-2:0], link.refresh};
    end
  end

  // Filtered levels; a one-sample glitch never counts
  always_ff @(posedge clock) begin
    if (reset) begin
      odt_s        <= 1'b0;
      cke_s        <= 1'b0;
      cke_prev     <= 1'b0;
      powered_down <= 1'b0;
    end else begin
      odt_s        <= next_odt_s;
      cke_s        <= next_cke_s;
      cke_prev     <= cke_s;
      powered_down <= ~cke_s;
    end
  end

  // Load strobe comes from logic on this clock, so no filter
  always_ff @(posedge clock) begin
    if (reset) begin
      mr0 <= MR0_RESET;
    end else if (link.mr0_load) begin
      mr0 <= link.mr0_value;
    end
  end

  // Synchronous latency pipe, tapped at ODTLon and ODTLoff
  always_ff @(posedge clock) begin
    if (reset) begin
      odt_pipe <= '0;
    end else begin
      odt_pipe <= {odt_pipe[PIPE_DEPTH-2:0], odt_s};
    end
  end

  // Separate counters so entry and exit windows may overlap
  always_ff @(posedge clock) begin
    if (reset) begin
      pde_cnt <= CNT_ZERO;
      pdx_cnt <= CNT_ZERO;
    end else begin
      pde_cnt <= next_pde;
      pdx_cnt <= next_pdx;
    end
  end

  // Refresh time still to run
  always_ff @(posedge clock) begin
    if (reset) begin
      rfc_cnt <= CNT_ZERO;
    end else begin
      rfc_cnt <= next_rfc;
    end
  end

  // Analog delay model; one cycle already exceeds the shortest delay
  always_ff @(posedge clock) begin
    if (reset) begin
      async_cnt <= CNT_ZERO;
      async_tgt <= 1'b0;
    end else begin
      async_cnt <= next_async;
      async_tgt <= odt_s;
    end
  end

  // Registered outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      rtt_on <= 1'b0;
      mode   <= ODT_MODE_SYNC;
      window <= 1'b0;
    end else begin
      rtt_on <= next_rtt;
      mode   <= next_mode;
      window <= in_win;
    end
  end
endmodule // odt_device

// File: include/odt_pkg.sv
// Shared constants and types for the termination transition logic
package odt_pkg;
  localparam int unsigned CLK_PERIOD_PS     = 25000;
  localparam int unsigned ASYNC_MIN_PS      = 2000;
  localparam int unsigned ASYNC_MAX_PS      = 8500;
  // Least delay rounds up, longest rounds down, never below one cycle
  localparam int unsigned ASYNC_MIN_CYC_RAW =
    (ASYNC_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ASYNC_MAX_CYC_RAW = ASYNC_MAX_PS / CLK_PERIOD_PS;
  localparam int unsigned ASYNC_MIN_CYC =
    (ASYNC_MIN_CYC_RAW < 1) ? 1 : ASYNC_MIN_CYC_RAW;
  localparam int unsigned ASYNC_MAX_CYC =
    (ASYNC_MAX_CYC_RAW < 1) ? 1 : ASYNC_MAX_CYC_RAW;
  localparam int unsigned ASYNC_CYC = ASYNC_MIN_CYC;
  localparam int unsigned LAT_W      = 5;
  localparam int unsigned CNT_W      = 8;
  localparam logic [LAT_W-1:0] ODTL_SUB  = 5'h02;
  localparam logic [LAT_W-1:0] ANPD_SUB  = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;
  localparam int unsigned DLL_OFF_BIT    = 12;
  localparam int unsigned MR0_W          = 16;
  localparam logic [MR0_W-1:0] MR0_RESET = 16'h0000;
  localparam int unsigned PIPE_DEPTH     = 32;
  localparam int unsigned PIN_SYNC       = 3;
  typedef enum logic [1:0] {
    ODT_MODE_SYNC,
    ODT_MODE_ASYNC,
    ODT_MODE_MIXED
  } odt_mode_t;
endpackage

// File: include/odt_link_if.sv
// Link between memory controller and termination control in the DRAM
interface odt_link_if;
  logic odt;
  logic cke;
  logic refresh;
  logic mr0_load;
  logic [odt_pkg::MR0_W-1:0] mr0_value;
  modport device (
    input odt,
    input cke,
    input refresh,
    input mr0_load,
    input mr0_value
  );
  modport host (
    output odt,
    output cke,
    output refresh,
    output mr0_load,
    output mr0_value
  );
endinterface

// File: src/odt_host.sv
// Controller-side driver of ODT, CKE, refresh and mode register
module odt_host (
  input  wire logic                    clock,
  input  wire logic                    reset,
  odt_link_if.host                     link,
  input  wire logic                    req_odt,
  input  wire logic                    req_cke,
  input  wire logic                    req_refresh,
  input  wire logic                    req_mr0,
  input  wire logic [odt_pkg::MR0_W-1:0] req_mr0_value
);
  import odt_pkg::*;

  // Registered drive keeps pins glitch free; the user must hold ODT
  // steady across CKE windows or budget the widest limits
  always_ff @(posedge clock) begin
    if (reset) begin
      link.odt       <= 1'b0;
      link.cke       <= 1'b0;
      link.refresh   <= 1'b0;
      link.mr0_load  <= 1'b0;
      link.mr0_value <= MR0_RESET;
    end else begin
      link.odt       <= req_odt;
      link.cke       <= req_cke;
      link.refresh   <= req_refresh;
      link.mr0_load  <= req_mr0;
      link.mr0_value <= req_mr0_value;
    end
  end
endmodule // odt_host

// File: tb/odt_checker.sv
// Checker for termination timing across power-down transitions
module odt_checker (
  input wire logic                     clock,
  input wire logic                     reset,
  input wire logic                     odt,
  input wire logic                     cke,
  input wire logic                     mr0_load,
  input wire logic [odt_pkg::MR0_W-1:0] mr0_value,
  input wire logic                     rtt_on,
  input wire odt_pkg::odt_mode_t       mode,
  input wire logic                     window
);
  import odt_pkg::*;
  logic       dll_on;
  logic [5:0] cke_hist;
  // Recent CKE samples, so a short low pulse is not taken for an exit
  always_ff @(posedge clock) begin
    if (reset)
      cke_hist <= '0;
    else
      cke_hist <= {cke_hist[4:0], cke};
  end
  // Mirror of the DLL bit, so window checks know which regime holds
  always_ff @(posedge clock) begin
    if (reset)
      dll_on <= 1'b0;
    else if (mr0_load)
      dll_on <= mr0_value[DLL_OFF_BIT];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence exit_open;
    $rose(window) && cke && (&cke_hist);
  endsequence
  sequence entry_open;
    $rose(window) && !cke;
  endsequence
  no_window_a: assert property (
    dll_on && !window |=> !window)
    else $error("window opened with dll kept on");
  window_mode_a: assert property (
    window |-> mode == ODT_MODE_MIXED)
    else $error("mode not mixed inside window");
  exit_len_a: assert property (
    exit_open |-> window[*8] ##6 window ##1 !window)
    else $error("exit window length wrong");
  entry_len_a: assert property (
    entry_open |-> window[*4])
    else $error("entry window too short");
  to_async_a: assert property (
    $fell(window) && !cke |-> ##[0:1] mode == ODT_MODE_ASYNC)
    else $error("no async mode after entry");
  to_sync_a: assert property (
    $fell(window) && cke |-> ##[0:1] mode == ODT_MODE_SYNC)
    else $error("no sync mode after exit");
  sync_on_a: assert property (
    mode == ODT_MODE_SYNC && !window && $rose(odt)
    |-> !rtt_on[*5] ##[1:5] rtt_on)
    else $error("sync turn-on latency wrong");
  sync_off_a: assert property (
    mode == ODT_MODE_SYNC && !window && $fell(odt)
    |-> rtt_on[*5] ##[1:5] !rtt_on)
    else $error("sync turn-off latency wrong");
  async_on_a: assert property (
    mode == ODT_MODE_ASYNC && $rose(odt) |-> ##[1:7] rtt_on)
    else $error("async turn-on late");
  async_off_a: assert property (
    mode == ODT_MODE_ASYNC && $fell(odt) |-> ##[1:7] !rtt_on)
    else $error("async turn-off late");
endmodule // odt_checker

// File: tb/odt_powerdown_mode_transition_tb.sv
// Bench joining host and device ends across the termination link
module odt_powerdown_mode_transition_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import odt_pkg::*;
  localparam int CWL = 5, AL = 0, XPDLL = 10, RFC = 11;
  localparam int WL = CWL + AL;
  logic clock, reset, req_odt, req_cke, req_refresh, req_mr0;
  logic [MR0_W-1:0] req_mr0_value;
  logic rtt_on, window;
  odt_mode_t mode;
  int errors = 0, checked = 0, n;
  odt_link_if link ();
  odt_host odt_host_i (.clock(clock), .reset(reset), .link(link.host),
    .req_odt(req_odt), .req_cke(req_cke), .req_refresh(req_refresh),
    .req_mr0(req_mr0), .req_mr0_value(req_mr0_value));
  odt_device #(.CWL(CWL), .AL(AL), .XPDLL(XPDLL), .RFC(RFC)) odt_device_i (
    .clock(clock), .reset(reset), .link(link.device), .rtt_on(rtt_on),
    .mode(mode), .window(window));
  odt_checker odt_checker_i (.clock(clock), .reset(reset), .odt(link.odt),
    .cke(link.cke), .mr0_load(link.mr0_load), .mr0_value(link.mr0_value),
    .rtt_on(rtt_on), .mode(mode), .window(window));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic end_sim();
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // Drives at a rising edge, then waits to falling edges to sample
  task automatic drive(input logic o, c, r, input int w);
    @(posedge clock);
    req_odt <= o;
    req_cke <= c;
    req_refresh <= r;
    repeat (w) @(negedge clock);
  endtask
  task automatic load_mr0(input logic [MR0_W-1:0] v);
    @(posedge clock);
    req_mr0 <= 1'b1;
    req_mr0_value <= v;
    @(posedge clock);
    req_mr0 <= 1'b0;
    repeat (4) @(negedge clock);
  endtask
  // Bounded wait for the window, then its length in cycles
  task automatic win_len();
    int t;
    n = 0;
    for (t = 0; t < 20 && window !== 1'b1; t++) @(negedge clock);
    while (window === 1'b1 && n < 60) begin
      n++;
      @(negedge clock);
    end
  endtask
  initial begin
    {req_odt, req_cke, req_refresh, req_mr0} = 4'h0;
    req_mr0_value = 16'h0000;
    reset = 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    load_mr0(16'h0a52);
    drive(0, 1, 0, 1);
    win_len();
    check(n == WL - 1 + XPDLL, "exit len");
    check(mode === ODT_MODE_SYNC, "mode after exit");
    drive(1, 1, 0, 4);
    check(rtt_on === 1'b0, "sync on early");
    drive(1, 1, 0, 8);
    check(rtt_on === 1'b1, "sync on");
    drive(0, 1, 0, 4);
    check(rtt_on === 1'b1, "sync off early");
    drive(0, 1, 0, 8);
    check(rtt_on === 1'b0, "sync off");
    drive(0, 0, 0, 1);
    win_len();
    check(n == WL - 1, "entry len");
    check(mode === ODT_MODE_ASYNC, "mode after entry");
    drive(1, 0, 0, 8);
    check(rtt_on === 1'b1, "async on");
    drive(0, 0, 0, 8);
    check(rtt_on === 1'b0, "async off");
    drive(0, 1, 0, 1);
    win_len();
    drive(0, 1, 1, 3);
    drive(0, 0, 0, 1);
    win_len();
    check(n >= RFC - 4 && n <= RFC - 2, "rfc");
    drive(0, 1, 0, 1);
    win_len();
    drive(0, 0, 0, 2);
    drive(0, 1, 0, 1);
    win_len();
    check(n >= WL - 1 + XPDLL, "merged");
    load_mr0(16'h1000);
    drive(0, 0, 0, 1);
    win_len();
    check(n == 0, "dll on window");
    end_sim();
  end
  initial begin
    repeat (2000) @(posedge clock);
    errors++;
    end_sim();
  end
endmodule // odt_powerdown_mode_transition_tb
